// *** aipc_chain.sv ***
// audio input processing chain: decimator, lpf, down-sampler, hpf, level control
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module aipc_chain (
  input wire logic core_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // samples from the source front end
  input wire aipc_pkg::aipc_smp_t smp_in,
  // samples to the fifo writers
  output aipc_pkg::aipc_smp_t smp_out,
  // analog amplifier gain in half dB, per channel
  output logic [7:0] amp_gain_l,
  output logic [7:0] amp_gain_r
);
  // all state in one struct
  typedef struct packed {
    aipc_pkg::aipc_regs_t regs;
    aipc_pkg::aipc_bus_st_t bst;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic [8:0] dec_cnt;
    logic signed [aipc_pkg::ACCW-1:0] acc_l;
    logic signed [aipc_pkg::ACCW-1:0] acc_r;
    aipc_pkg::aipc_smp_t s1;
    aipc_pkg::aipc_smp_t s2;
    logic signed [aipc_pkg::SW-1:0] lpf_pl;
    logic signed [aipc_pkg::SW-1:0] lpf_pr;
    logic ds_ph;
    aipc_pkg::aipc_smp_t s3;
    aipc_pkg::aipc_smp_t s4;
    logic signed [aipc_pkg::ACCW-1:0] dc_l;
    logic signed [aipc_pkg::ACCW-1:0] dc_r;
    aipc_pkg::aipc_smp_t so;
    logic [6:0] ag_l;
    logic [6:0] ag_r;
    logic [6:0] dg_l;
    logic [6:0] dg_r;
    logic [7:0] lvl_l;
    logic [7:0] lvl_r;
    logic [7:0] spd_cnt;
    logic [7:0] amp_l;
    logic [7:0] amp_r;
  } st_t;

  st_t q, d;

  // decimation ratio from the four-bit code
  function automatic logic [8:0] dec_ratio(input logic [3:0] c);
    logic [8:0] r;
    r = 9'h100;
    if (c < 4'h8) begin
      r = {5'h00, c} + 9'h001;
    end else if (c < 4'hc) begin
      r = 9'h010 << c[1:0];
    end
    return r;
  endfunction

  // saturate a wide value to a sample word
  function automatic logic signed [15:0] sat(input logic signed [31:0] v);
    logic signed [15:0] o;
    o = v[15:0];
    if (v > 32'sh0000_7fff) begin
      o = 16'sh7fff;
    end else if (v < -32'sh0000_8000) begin
      o = -16'sh8000;
    end
    return o;
  endfunction

  // magnitude level in half dB (about 6 dB per bit of magnitude)
  function automatic logic [7:0] level_hdb(input logic signed [15:0] v);
    logic [15:0] m;
    logic [7:0] o;
    m = v[15] ? 16'(-v) : v;
    o = 8'h00;
    for (int i = 0; i < 16; i++) begin
      if (m[i]) begin
        o = 8'(i * 12);
      end
    end
    return o;
  endfunction

  // digital gain: gain/32 scaling, 0x20 is unity
  function automatic logic signed [15:0] scale(input logic signed [15:0] v, input logic [6:0] g);
    logic signed [31:0] p;
    p = 32'(v) * $signed({25'h000_0000, g});
    return sat(p >>> 5);
  endfunction

  // one step of automatic regulation toward the targets
  function automatic logic [6:0] regulate(input logic [6:0] g, input logic [7:0] lvl,
                                          input logic [7:0] mn, input aipc_pkg::aipc_regs_t r);
    logic [6:0] n;
    n = g;
    // thresholds: [6:1] integer dB and [0] half dB give half-dB units directly
    if (lvl > {1'b0, r.thh[6:0]}) begin
      n = g - 7'h01;
    end else if (lvl < {1'b0, r.thl[6:0]} && lvl > {1'b0, r.thn[6:0]}) begin
      n = g + 7'h01;
    end
    if (n > r.max[6:0]) begin
      n = r.max[6:0];
    end
    if (n < mn[6:0]) begin
      n = mn[6:0];
    end
    return n;
  endfunction

  // combinational next state
  always_comb begin
    logic [11:0] idx;
    logic [8:0] ratio;
    logic signed [aipc_pkg::ACCW-1:0] a_l;
    logic signed [aipc_pkg::ACCW-1:0] a_r;
    logic analog_mode;
    logic man1;
    logic analog_mic_input;
    logic signed [15:0] hl;
    logic signed [15:0] hr;
    logic [7:0] post_hdb;
    d = q;
    idx = paddr[13:2];
    ratio = dec_ratio(q.regs.dec[3:0]);
    analog_mode = q.regs.mode[0];
    man1 = q.regs.man[aipc_pkg::MAN1_SEL_BIT];
    analog_mic_input = (q.regs.in_cfg[3:2] == aipc_pkg::SRC_ANALOG_MIC);
    a_l = '0;
    a_r = '0;
    hl = '0;
    hr = '0;
    post_hdb = '0;

    // apb: one wait state, answer in the second access cycle
    d.rdy = 1'b0;
    d.err = 1'b0;
    case (q.bst)
      aipc_pkg::ST_IDLE: begin
        if (psel && !penable) begin
          d.bst = aipc_pkg::ST_ACCESS;
        end
      end
      aipc_pkg::ST_ACCESS: begin
        if (psel && penable && !q.rdy) begin
          d.rdy = 1'b1;
          d.rdata = '0;
          case (idx)
            aipc_pkg::IDX_IN_CFG: d.rdata[7:0] = q.regs.in_cfg;
            aipc_pkg::IDX_DEC: d.rdata[7:0] = q.regs.dec;
            aipc_pkg::IDX_FILT: d.rdata[7:0] = q.regs.filt;
            aipc_pkg::IDX_MIN_L: d.rdata[7:0] = q.regs.min_l;
            aipc_pkg::IDX_MIN_R: d.rdata[7:0] = q.regs.min_r;
            aipc_pkg::IDX_MAX: d.rdata[7:0] = q.regs.max;
            aipc_pkg::IDX_THH: d.rdata[7:0] = q.regs.thh;
            aipc_pkg::IDX_THL: d.rdata[7:0] = q.regs.thl;
            aipc_pkg::IDX_THN: d.rdata[7:0] = q.regs.thn;
            aipc_pkg::IDX_MODE: d.rdata[7:0] = q.regs.mode;
            aipc_pkg::IDX_SPEED: d.rdata[7:0] = q.regs.speed;
            aipc_pkg::IDX_MAN: d.rdata[7:0] = q.regs.man;
            aipc_pkg::IDX_TGT_L: d.rdata[7:0] = q.regs.tgt_l;
            aipc_pkg::IDX_TGT_R: d.rdata[7:0] = q.regs.tgt_r;
            // manual modes show the level at the controller input instead
            aipc_pkg::IDX_DG_L: d.rdata[7:0] = q.regs.min_l[7] ? {1'b0, q.dg_l} : q.lvl_l;
            aipc_pkg::IDX_DG_R: d.rdata[7:0] = q.regs.min_r[7] ? {1'b0, q.dg_r} : q.lvl_r;
            aipc_pkg::IDX_AG_L: d.rdata[7:0] = {1'b0, q.ag_l};
            aipc_pkg::IDX_AG_R: d.rdata[7:0] = {1'b0, q.ag_r};
            aipc_pkg::IDX_RAMP_L: d.rdata[7:0] = {1'b0, q.ag_l};
            aipc_pkg::IDX_RAMP_R: d.rdata[7:0] = {1'b0, q.ag_r};
            default: d.err = 1'b1; // unmapped answers with an error
          endcase
          if (pwrite) begin
            d.rdata = '0;
            d.err = 1'b0;
            case (idx)
              aipc_pkg::IDX_IN_CFG: d.regs.in_cfg = pwdata[7:0];
              aipc_pkg::IDX_DEC: d.regs.dec = pwdata[7:0];
              aipc_pkg::IDX_FILT: d.regs.filt = pwdata[7:0];
              aipc_pkg::IDX_MIN_L: d.regs.min_l = pwdata[7:0];
              aipc_pkg::IDX_MIN_R: d.regs.min_r = pwdata[7:0];
              aipc_pkg::IDX_MAX: d.regs.max = pwdata[7:0];
              aipc_pkg::IDX_THH: d.regs.thh = pwdata[7:0];
              aipc_pkg::IDX_THL: d.regs.thl = pwdata[7:0];
              aipc_pkg::IDX_THN: d.regs.thn = pwdata[7:0];
              aipc_pkg::IDX_MODE: d.regs.mode = pwdata[7:0];
              aipc_pkg::IDX_SPEED: d.regs.speed = pwdata[7:0];
              aipc_pkg::IDX_MAN: d.regs.man = pwdata[7:0];
              // a new target clears the reached flag
              aipc_pkg::IDX_TGT_L: d.regs.tgt_l = {1'b0, pwdata[6:0]};
              aipc_pkg::IDX_TGT_R: d.regs.tgt_r = {1'b0, pwdata[6:0]};
              aipc_pkg::IDX_DG_L, aipc_pkg::IDX_DG_R, aipc_pkg::IDX_AG_L, aipc_pkg::IDX_AG_R,
              aipc_pkg::IDX_RAMP_L, aipc_pkg::IDX_RAMP_R: d.err = 1'b0; // read-only, write ignored
              default: d.err = 1'b1;
            endcase
          end
        end else if (q.rdy) begin
          d.bst = aipc_pkg::ST_IDLE;
        end
      end
      default: d.bst = aipc_pkg::ST_IDLE;
    endcase

    // stage 1: decimator as a boxcar integrator dumped every ratio samples
    d.s1.vld = 1'b0;
    if (smp_in.vld) begin
      if (q.regs.in_cfg[aipc_pkg::DEC_BYP_BIT]) begin
        d.s1 = smp_in;
      end else begin
        a_l = q.acc_l + aipc_pkg::ACCW'(smp_in.l);
        a_r = q.acc_r + aipc_pkg::ACCW'(smp_in.r);
        if (q.dec_cnt + 9'h001 >= ratio) begin
          d.dec_cnt = '0;
          d.acc_l = '0;
          d.acc_r = '0;
          d.s1.vld = 1'b1;
          d.s1.l = sat(32'(a_l >>> q.regs.dec[7:4]));
          d.s1.r = sat(32'(a_r >>> q.regs.dec[7:4]));
        end else begin
          d.dec_cnt = q.dec_cnt + 9'h001;
          d.acc_l = a_l;
          d.acc_r = a_r;
        end
      end
    end

    // stage 2: two-tap averaging lpf
    d.s2.vld = q.s1.vld;
    if (q.s1.vld) begin
      d.lpf_pl = q.s1.l;
      d.lpf_pr = q.s1.r;
      if (q.regs.filt[aipc_pkg::LPF_BYP_BIT]) begin
        d.s2 = q.s1;
      end else begin
        d.s2.l = 16'((17'(q.s1.l) + 17'(q.lpf_pl)) >>> 1);
        d.s2.r = 16'((17'(q.s1.r) + 17'(q.lpf_pr)) >>> 1);
      end
    end

    // stage 3: keep one of every two samples when enabled
    d.s3.vld = 1'b0;
    if (q.s2.vld) begin
      d.s3.l = q.s2.l;
      d.s3.r = q.s2.r;
      if (q.regs.filt[aipc_pkg::DS_EN_BIT]) begin
        d.ds_ph = !q.ds_ph;
        d.s3.vld = !q.ds_ph;
      end else begin
        d.s3.vld = 1'b1;
      end
    end

    // stage 4: dc tracking hpf, pole set by the parameter field
    d.s4.vld = q.s3.vld;
    if (q.s3.vld) begin
      hl = sat(32'(q.s3.l) - 32'(q.dc_l >>> 8));
      hr = sat(32'(q.s3.r) - 32'(q.dc_r >>> 8));
      if (q.regs.filt[aipc_pkg::HPF_BYP_BIT]) begin
        d.s4.l = q.s3.l;
        d.s4.r = q.s3.r;
      end else begin
        d.s4.l = hl;
        d.s4.r = hr;
        d.dc_l = q.dc_l + aipc_pkg::ACCW'(($signed(acc_widen(hl)) <<< 8) >>> q.regs.filt[3:0]);
        d.dc_r = q.dc_r + aipc_pkg::ACCW'(($signed(acc_widen(hr)) <<< 8) >>> q.regs.filt[3:0]);
      end
    end

    // stage 5: level control
    d.so.vld = q.s4.vld;
    if (q.s4.vld) begin
      d.lvl_l = level_hdb(q.s4.l);
      d.lvl_r = level_hdb(q.s4.r);
      d.so.l = q.s4.l;
      d.so.r = q.s4.r;
      if (!analog_mode) begin
        // digital mode applies to any source
        d.so.l = scale(q.s4.l, q.regs.min_l[7] ? q.dg_l : {1'b0, q.regs.min_l[5:0]});
        d.so.r = scale(q.s4.r, q.regs.min_r[7] ? q.dg_r : {1'b0, q.regs.min_r[5:0]});
        if (q.regs.min_l[aipc_pkg::AUTO_EN_BIT]) begin
          d.dg_l = regulate(q.dg_l, level_hdb(scale(q.s4.l, q.dg_l)), q.regs.min_l, q.regs);
        end
        if (q.regs.min_r[aipc_pkg::AUTO_EN_BIT]) begin
          d.dg_r = regulate(q.dg_r, level_hdb(scale(q.s4.r, q.dg_r)), q.regs.min_r, q.regs);
        end
      end else if (analog_mic_input) begin
        // analog auto: gained level is input level plus amplifier gain
        if (q.regs.min_l[aipc_pkg::AUTO_EN_BIT]) begin
          d.ag_l = regulate(q.ag_l, 8'(level_hdb(q.s4.l) + {1'b0, q.ag_l}), q.regs.min_l, q.regs);
        end
        if (q.regs.min_r[aipc_pkg::AUTO_EN_BIT]) begin
          d.ag_r = regulate(q.ag_r, 8'(level_hdb(q.s4.r) + {1'b0, q.ag_r}), q.regs.min_r, q.regs);
        end
      end
    end

    // manual mode 2: ramp amplifier gain one step per speed period
    if (!man1 && !analog_mode) begin
      d.spd_cnt = q.spd_cnt + 8'h01;
      if (q.spd_cnt >= q.regs.speed) begin
        d.spd_cnt = '0;
        if (q.ag_l < q.regs.tgt_l[6:0]) d.ag_l = q.ag_l + 7'h01;
        else if (q.ag_l > q.regs.tgt_l[6:0]) d.ag_l = q.ag_l - 7'h01;
        if (q.ag_r < q.regs.tgt_r[6:0]) d.ag_r = q.ag_r + 7'h01;
        else if (q.ag_r > q.regs.tgt_r[6:0]) d.ag_r = q.ag_r - 7'h01;
      end
      // reached flag is set by hardware and wins over a same-cycle target write
      if (q.ag_l == q.regs.tgt_l[6:0]) d.regs.tgt_l[aipc_pkg::REACHED_BIT] = 1'b1;
      if (q.ag_r == q.regs.tgt_r[6:0]) d.regs.tgt_r[aipc_pkg::REACHED_BIT] = 1'b1;
    end

    // amplifier drive in half dB: manual mode 1 uses fixed stages
    if (man1) begin
      post_hdb = (q.regs.man[5:0] > aipc_pkg::POST_MAX) ? {2'b00, aipc_pkg::POST_MAX} : {2'b00, q.regs.man[5:0]};
      post_hdb = 8'(post_hdb + 8'(aipc_pkg::POST_MIN_HALF_DB));
      d.amp_l = 8'((q.regs.man[aipc_pkg::PRE_GAIN_BIT] ? aipc_pkg::PRE_HI_HDB : aipc_pkg::PRE_LO_HDB)
                   + post_hdb);
      d.amp_r = d.amp_l;
    end else begin
      d.amp_l = {1'b0, q.ag_l};
      d.amp_r = {1'b0, q.ag_r};
    end
  end

  // widen a sample to the accumulator width
  function automatic logic signed [aipc_pkg::ACCW-1:0] acc_widen(input logic signed [15:0] v);
    return aipc_pkg::ACCW'(v);
  endfunction

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
      q.regs.in_cfg <= aipc_pkg::RST_IN_CFG;
      q.regs.dec <= aipc_pkg::RST_DEC;
      q.regs.max <= {1'b0, aipc_pkg::RST_MAX_GAIN};
      q.dg_l <= aipc_pkg::UNITY_GAIN;
      q.dg_r <= aipc_pkg::UNITY_GAIN;
      q.bst <= aipc_pkg::ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state
  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign smp_out = q.so;
  assign amp_gain_l = q.amp_l;
  assign amp_gain_r = q.amp_r;
endmodule
`default_nettype wire

// *** aipc_pkg.sv ***
// package for the audio input processing chain: register map, fields, types
package aipc_pkg;
  // register word indices (offsets not multiples of four: byte address is index times four)
  localparam logic [11:0] IDX_IN_CFG = 12'h0b11;
  localparam logic [11:0] IDX_DEC = 12'h0b12;
  localparam logic [11:0] IDX_FILT = 12'h0b40;
  localparam logic [11:0] IDX_MIN_L = 12'h0b41;
  localparam logic [11:0] IDX_MIN_R = 12'h0b42;
  localparam logic [11:0] IDX_MAX = 12'h0b43;
  localparam logic [11:0] IDX_THH = 12'h0b44;
  localparam logic [11:0] IDX_THL = 12'h0b46;
  localparam logic [11:0] IDX_THN = 12'h0b48;
  localparam logic [11:0] IDX_DG_L = 12'h0b4d;
  localparam logic [11:0] IDX_DG_R = 12'h0b4e;
  localparam logic [11:0] IDX_MODE = 12'h0b54;
  localparam logic [11:0] IDX_AG_L = 12'h0b5e;
  localparam logic [11:0] IDX_AG_R = 12'h0b5f;
  localparam logic [11:0] IDX_SPEED = 12'h0b60;
  localparam logic [11:0] IDX_TGT_L = 12'h0b61;
  localparam logic [11:0] IDX_RAMP_L = 12'h0b62;
  localparam logic [11:0] IDX_MAN = 12'h0b63;
  localparam logic [11:0] IDX_TGT_R = 12'h0b65;
  localparam logic [11:0] IDX_RAMP_R = 12'h0b66;
  // field positions
  localparam int DEC_BYP_BIT = 5;
  localparam int HPF_BYP_BIT = 4;
  localparam int LPF_BYP_BIT = 6;
  localparam int DS_EN_BIT = 7;
  localparam int AUTO_EN_BIT = 7;
  localparam int MAN1_SEL_BIT = 7;
  localparam int PRE_GAIN_BIT = 6;
  localparam int REACHED_BIT = 7;
  // source select value for the analog microphone path (field [3:2])
  localparam logic [1:0] SRC_ANALOG_MIC = 2'h2;
  // reset values
  localparam logic [7:0] RST_IN_CFG = 8'h21;
  localparam logic [7:0] RST_DEC = 8'h5b;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [6:0] RST_MAX_GAIN = 7'h7f;
  localparam logic [6:0] UNITY_GAIN = 7'h20;
  // post-amplifier code ceiling, and the gain figures of the stages (dB and half dB)
  localparam logic [5:0] POST_MAX = 6'h30;
  localparam int PRE_LO_DB = 18;
  localparam int PRE_HI_DB = 38;
  localparam int POST_MIN_HALF_DB = -20;
  localparam logic [7:0] PRE_LO_HDB = 8'(PRE_LO_DB * 2);
  localparam logic [7:0] PRE_HI_HDB = 8'(PRE_HI_DB * 2);
  // sample word and the accumulator of the decimator
  localparam int SW = 16;
  localparam int ACCW = 24;

  typedef struct packed {
    logic [7:0] in_cfg;
    logic [7:0] dec;
    logic [7:0] filt;
    logic [7:0] min_l;
    logic [7:0] min_r;
    logic [7:0] max;
    logic [7:0] thh;
    logic [7:0] thl;
    logic [7:0] thn;
    logic [7:0] mode;
    logic [7:0] speed;
    logic [7:0] tgt_l;
    logic [7:0] tgt_r;
    logic [7:0] man;
  } aipc_regs_t;

  // one stereo sample with its strobe
  typedef struct packed {
    logic vld;
    logic signed [SW-1:0] l;
    logic signed [SW-1:0] r;
  } aipc_smp_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS} aipc_bus_st_t;
endpackage

// *** aipc_chain_sva.sv ***
// port checker of the audio input processing chain, bound to its top
`timescale 1ns/1ps
`default_nettype none
module aipc_chain_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire aipc_pkg::aipc_smp_t smp_in,
  input wire aipc_pkg::aipc_smp_t smp_out,
  input wire logic [7:0] amp_gain_l,
  input wire logic [7:0] amp_gain_r
);
  logic [7:0] cfg_q; // shadow of the input path config
  logic [7:0] filt_q; // shadow of the filter stage control
  logic [7:0] man_q; // shadow of the manual stage gain
  logic wr_ok; // a write that the slave accepted
  logic byp_all; // every filter stage bypassed, no down-sampling
  logic [7:0] m1_gain; // expected manual mode 1 total gain, half dB
  logic m1_ok; // both amplifier outputs show the expected manual gain
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign byp_all = cfg_q[5] && filt_q[6] && filt_q[4] && !filt_q[7];
  assign m1_gain = (man_q[6] ? aipc_pkg::PRE_HI_HDB : aipc_pkg::PRE_LO_HDB) + {2'b00, man_q[5:0]} - 8'h14;
  assign m1_ok = (amp_gain_l == m1_gain) && (amp_gain_r == m1_gain);
  // shadows follow accepted writes only, so a refused access changes nothing
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_q <= aipc_pkg::RST_IN_CFG;
      filt_q <= aipc_pkg::RST_ZERO;
      man_q <= aipc_pkg::RST_ZERO;
    end else if (wr_ok) begin
      if (paddr == {aipc_pkg::IDX_IN_CFG, 2'b00}) cfg_q <= pwdata[7:0];
      if (paddr == {aipc_pkg::IDX_FILT, 2'b00}) filt_q <= pwdata[7:0];
      if (paddr == {aipc_pkg::IDX_MAN, 2'b00}) man_q <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_ready_delay: assert property (psel && !penable |-> ##2 pready) else $error("apb answer late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_idle_quiet: assert property (!psel |-> !pready && !pslverr) else $error("answer without request");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  // all filter stages forward unchanged, so each strobe reappears after a fixed delay
  a_bypass_lat: assert property (byp_all && smp_in.vld |-> ##5 smp_out.vld) else $error("bypass latency wrong");
  // gain may take a few cycles to settle after a change of the stage code
  a_man1_gain: assert property ((man_q[7] && $stable(man_q))[*3] |-> m1_ok)
    else $error("manual gain wrong");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !pready && !smp_out.vld && amp_gain_l == 8'h00)
    else $error("outputs active after reset");
  c_refused: cover property (pslverr);
  c_bypass_out: cover property (byp_all && smp_out.vld);
  c_man1: cover property (man_q[7] && amp_gain_l != 8'h00);
endmodule
bind aipc_chain aipc_chain_sva u_sva (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .smp_in(smp_in), .smp_out(smp_out), .amp_gain_l(amp_gain_l), .amp_gain_r(amp_gain_r));
`default_nettype wire

// *** aipc_src_model.sv ***
// source front end and fifo writer model around the chain
`timescale 1ns/1ps
`default_nettype none
module aipc_src_model (
  input wire logic core_clk,
  output var aipc_pkg::aipc_smp_t smp_in,
  input wire aipc_pkg::aipc_smp_t smp_out
);
  aipc_pkg::aipc_smp_t inq[$]; // samples waiting to be sent
  aipc_pkg::aipc_smp_t outq[$]; // samples taken by the fifo side
  initial smp_in = '0;
  // one sample per edge; between strobes data toggles so nothing stale looks valid
  always @(posedge core_clk) begin
    if (smp_out.vld === 1'b1) outq.push_back(smp_out);
    if (inq.size() > 0) smp_in <= inq.pop_front();
    else smp_in <= '{vld: 1'b0, l: ~smp_in.l, r: ~smp_in.r};
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench of the audio input processing chain
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] amp_gain_l, amp_gain_r, rd;
  aipc_pkg::aipc_smp_t smp_in, smp_out;
  int fails, checks_done;
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  aipc_chain dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smp_in(smp_in), .smp_out(smp_out), .amp_gain_l(amp_gain_l), .amp_gain_r(amp_gain_r));
  aipc_src_model src (.core_clk(core_clk), .smp_in(smp_in), .smp_out(smp_out));
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one apb transfer; read data and error land in rd and er
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      complete_run;
    end
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(nm, e, rd)
  endtask
  // queue samples of one value pair at the source
  task automatic push(input int n, input logic signed [15:0] l, input logic signed [15:0] r);
    repeat (n) src.inq.push_back('{vld: 1'b1, l: l, r: r});
  endtask
  // wait, bounded, until the source is empty, then let the pipeline drain
  task automatic drain;
    int k;
    for (k = 0; k < 2000 && src.inq.size() > 0; k++) @(posedge core_clk);
    if (k >= 2000) begin
      fails++;
      complete_run;
    end
    repeat (20) @(posedge core_clk);
  endtask
  // reset values, read-only writes and a refused address
  task automatic t_regs;
    rchk("in cfg reset", aipc_pkg::IDX_IN_CFG, 8'h21);
    rchk("ratio reset", aipc_pkg::IDX_DEC, 8'h5b);
    rchk("max reset", aipc_pkg::IDX_MAX, 8'h7f);
    rchk("filter reset", aipc_pkg::IDX_FILT, 8'h00);
    apb(1'b1, aipc_pkg::IDX_THH, 8'h5b);
    rchk("high target", aipc_pkg::IDX_THH, 8'h5b);
    apb(1'b1, aipc_pkg::IDX_AG_L, 8'h33);
    `CHK("ro no error", 1'b0, er)
    rchk("amp gain ro", aipc_pkg::IDX_AG_L, 8'h00);
    apb(1'b0, 12'h0b45, 8'h00);
    `CHK("unmapped error", 1'b1, er)
  endtask
  // bypass path, digital manual scaling, down-sampler and dc removal
  task automatic t_path;
    apb(1'b1, aipc_pkg::IDX_FILT, 8'h50);
    apb(1'b1, aipc_pkg::IDX_MIN_L, 8'h20);
    apb(1'b1, aipc_pkg::IDX_MIN_R, 8'h10);
    src.outq.delete();
    push(1, 16'sd1000, 16'sd1000);
    drain();
    `CHK("bypass count", 1, src.outq.size())
    `CHK("bypass left", 16'sd1000, src.outq[0].l)
    `CHK("half coefficient", 16'sd500, src.outq[0].r)
    apb(1'b1, aipc_pkg::IDX_FILT, 8'hd0);
    src.outq.delete();
    push(6, 16'sd100, 16'sd100);
    drain();
    `CHK("down-sample count", 3, src.outq.size())
    apb(1'b1, aipc_pkg::IDX_FILT, 8'h42);
    push(200, 16'sd1000, 16'sd1000);
    drain();
    `CHK("dc removed", 1'b1, src.outq[$].l < 16'sd500 && src.outq[$].l > -16'sd500)
  endtask
  // every ratio code class on a constant input, with a matching shift except shift 7 for ratio 256
  task automatic t_dec;
    int code[8] = '{0, 1, 3, 8, 9, 10, 11, 12};
    int sh[8] = '{0, 1, 2, 4, 5, 6, 7, 7};
    int ratio;
    apb(1'b1, aipc_pkg::IDX_FILT, 8'h50);
    apb(1'b1, aipc_pkg::IDX_IN_CFG, 8'h01);
    for (int i = 0; i < 8; i++) begin
      ratio = code[i] < 8 ? code[i] + 1 : (code[i] < 12 ? 16 << (code[i] - 8) : 256);
      apb(1'b1, aipc_pkg::IDX_DEC, 8'((sh[i] << 4) | code[i]));
      src.outq.delete();
      push(3 * ratio, 16'sd100, 16'sd100);
      drain();
      `CHK("decimated count", 1'b1, src.outq.size() >= 2 && src.outq.size() <= 3)
      `CHK("decimated value", 16'((100 * ratio) >> sh[i]), src.outq[$].l)
    end
  endtask
  // manual modes 1 and 2, then automatic clamping in both modes
  task automatic t_gain;
    apb(1'b1, aipc_pkg::IDX_MAN, 8'h80);
    repeat (4) @(posedge core_clk);
    `CHK("pre low post min", 8'h10, amp_gain_l)
    apb(1'b1, aipc_pkg::IDX_MAN, 8'hf0);
    repeat (4) @(posedge core_clk);
    `CHK("pre high post max", 8'h68, amp_gain_r)
    apb(1'b1, aipc_pkg::IDX_SPEED, 8'h01);
    apb(1'b1, aipc_pkg::IDX_TGT_L, 8'h0c);
    apb(1'b1, aipc_pkg::IDX_TGT_R, 8'h05);
    apb(1'b1, aipc_pkg::IDX_MAN, 8'h00);
    for (int k = 0; k < 1000 && amp_gain_l !== 8'h0c; k++) @(posedge core_clk);
    if (amp_gain_l !== 8'h0c) begin
      fails++;
      complete_run;
    end
    repeat (30) @(posedge core_clk);
    rchk("ramp left", aipc_pkg::IDX_RAMP_L, 8'h0c);
    rchk("reached left", aipc_pkg::IDX_TGT_L, 8'h8c);
    rchk("ramp right", aipc_pkg::IDX_RAMP_R, 8'h05);
    apb(1'b1, aipc_pkg::IDX_IN_CFG, 8'h29);
    apb(1'b1, aipc_pkg::IDX_MAX, 8'h0a);
    apb(1'b1, aipc_pkg::IDX_MIN_L, 8'h85);
    apb(1'b1, aipc_pkg::IDX_MODE, 8'h01);
    push(60, 16'sd20000, 16'sd20000);
    drain();
    apb(1'b0, aipc_pkg::IDX_AG_L, 8'h00);
    `CHK("analog auto clamp", 1'b1, rd >= 8'h05 && rd <= 8'h0a)
    // non-mic source: analog regulation must leave the gain below the raised minimum
    apb(1'b1, aipc_pkg::IDX_IN_CFG, 8'h21);
    apb(1'b1, aipc_pkg::IDX_MIN_L, 8'h88);
    push(60, 16'sd20000, 16'sd20000);
    drain();
    rchk("analog needs mic", aipc_pkg::IDX_AG_L, 8'h05);
    apb(1'b1, aipc_pkg::IDX_MODE, 8'h00);
    push(60, 16'sd20000, 16'sd20000);
    drain();
    apb(1'b0, aipc_pkg::IDX_DG_L, 8'h00);
    `CHK("digital auto clamp", 1'b1, rd >= 8'h05 && rd <= 8'h0a)
    apb(1'b0, aipc_pkg::IDX_DG_R, 8'h00);
    `CHK("manual input level", 8'ha8, rd)
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    fails = 0;
    checks_done = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_path();
    t_dec();
    t_gain();
    complete_run();
  end
endmodule
`default_nettype wire
